// >>> sync_serial_pkg.sv
// Register map, field positions and reset values of the synchronous serial unit
package sync_serial_pkg;
   localparam logic [7:0] ENABLE_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] TX_HOLD_OFFSET = 8'h08;
   localparam logic [7:0] RX_HOLD_OFFSET = 8'h0c;
   localparam logic [7:0] CTRL_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h18;
   localparam int TX_ALLOW_BIT = 7;
   localparam int RX_ALLOW_BIT = 6;
   localparam int RX_ONE_SHOT_BIT = 5;
   localparam int TX_DONE_IRQ_EN_BIT = 3;
   localparam int TX_EMPTY_IRQ_EN_BIT = 2;
   localparam int RX_IRQ_EN_BIT = 1;
   localparam int CONFLICT_IRQ_EN_BIT = 0;
   localparam int OVERRUN_BIT = 6;
   localparam int TX_DONE_BIT = 3;
   localparam int TX_EMPTY_BIT = 2;
   localparam int RX_FULL_BIT = 1;
   localparam int CONFLICT_BIT = 0;
   localparam logic [7:0] ENABLE_MASK = 8'hef;
   localparam logic [7:0] STATUS_MASK = 8'h4f;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h04;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_MSB_FIRST_BIT = 1;
   localparam logic [3:0] DIV_LAST = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : sync_serial_pkg

// >>> sync_serial_enable_status.sv
// Enable register, status flags, interrupts and byte engine of the synchronous serial unit
//
// Behaviour
// - Transmission runs only while tx_allow (enable bit 7) is 1; resets to 0.
// - Reception runs only while rx_allow (enable bit 6) is 1; resets to 0.
// - With rx_one_shot (bit 5) set, reception stops after one byte.
// - Enable bit 4 and status bits 7, 5, 4 always read 0.
// - Transmit-done request raised only while tx_done_irq_en (bit 3) is 1.
// - Transmit-empty request raised only while tx_empty_irq_en (bit 2) is 1.
// - rx_irq_en (bit 1) gates both receive-full and overrun requests.
// - Conflict request raised only while conflict_irq_en (bit 0) is 1.
// - Overrun flag (status bit 6) sets when a byte completes while receive-full is 1.
// - On overrun the holding register keeps the old byte; the new one is lost.
// - As master, transmission is also suspended while overrun is 1.
// - Writing 0 after reading 1 clears overrun and transmit-done flags.
// - Transmit-done (status bit 3) sets when last bit leaves and tx empty is 1.
// - Any write to the transmit holding register clears transmit-done.
// - Transmit-empty sets while tx_allow is 0 or when a byte enters the shifter.
// - Receive-full sets when a normal reception moves the byte to the holding register.
`timescale 1ns/1ps
module sync_serial_enable_status
   import sync_serial_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   input wire logic conflict_in,
   output logic serial_clk_out,
   output logic serial_clk_oe,
   output logic serial_data_out,
   output logic tx_done_irq,
   output logic tx_empty_irq,
   output logic rx_full_irq,
   output logic overrun_irq,
   output logic conflict_irq,
   output logic irq
);
   typedef enum logic [2:0] {
      IDLE = 3'b001,
      SHIFT = 3'b010,
      STOPPED = 3'b100
   } engine_state_type;

   logic [7:0] serial_enable_reg;
   logic [7:0] serial_status_reg;
   logic [7:0] tx_holding_reg;
   logic [7:0] rx_holding_reg;
   logic [7:0] shift_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic [7:0] read_seen;
   logic [2:0] bit_count;
   logic [3:0] div_count;
   logic [2:0] sclk_sync;
   logic [1:0] din_sync;
   logic [1:0] conf_sync;
   logic conf_prev;
   engine_state_type state;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held;
   logic w_held;
   logic do_write;
   logic do_read;
   logic master;
   logic msb_first;
   logic tx_allow;
   logic rx_allow;
   logic sclk_rise;
   logic sclk_fall;
   logic byte_end;
   logic load_tx;
   logic tx_write;
   logic status_write;
   logic [7:0] status_clear;
   logic [7:0] events;
   logic [7:0] next_status;
   logic [7:0] rx_word;
   logic [7:0] tx_rev;
   logic [7:0] rx_rev;

   assign master = ctrl_reg[CTRL_MASTER_BIT];
   assign msb_first = ctrl_reg[CTRL_MSB_FIRST_BIT];
   assign tx_allow = serial_enable_reg[TX_ALLOW_BIT];
   assign rx_allow = serial_enable_reg[RX_ALLOW_BIT];
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign tx_write = do_write && aw_addr == TX_HOLD_OFFSET && w_strb[0];
   assign status_write = do_write && aw_addr == STATUS_OFFSET && w_strb[0];

   // AXI write channels taken in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == RX_HOLD_OFFSET || aw_addr > IRQ_MASK_OFFSET ||
                            aw_addr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // AXI read channel, one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                          (!s_axi_rvalid && !do_read);
         if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
               ENABLE_OFFSET: s_axi_rdata <= {24'h0, serial_enable_reg & ENABLE_MASK};
               STATUS_OFFSET: s_axi_rdata <= {24'h0, serial_status_reg & STATUS_MASK};
               TX_HOLD_OFFSET: s_axi_rdata <= {24'h0, tx_holding_reg};
               RX_HOLD_OFFSET: s_axi_rdata <= {24'h0, rx_holding_reg};
               CTRL_OFFSET: s_axi_rdata <= {24'h0, ctrl_reg};
               IRQ_STAT_OFFSET: s_axi_rdata <= {24'h0, irq_stat};
               IRQ_MASK_OFFSET: s_axi_rdata <= {24'h0, irq_mask};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Plain control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_enable_reg <= ENABLE_RESET;
         ctrl_reg <= 8'h00;
         irq_mask <= 8'h00;
         tx_holding_reg <= HOLD_RESET;
      end else if (clk_en && do_write && w_strb[0]) begin
         unique case (aw_addr)
            ENABLE_OFFSET: serial_enable_reg <= w_data[7:0] & ENABLE_MASK;
            CTRL_OFFSET: ctrl_reg <= {6'h00, w_data[1:0]};
            IRQ_MASK_OFFSET: irq_mask <= w_data[7:0] & STATUS_MASK;
            TX_HOLD_OFFSET: tx_holding_reg <= w_data[7:0];
            default: ;
         endcase
      end
   end

   // Input synchronisers; first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Link clock idles high; starting there avoids a false edge after reset
         sclk_sync <= 3'b111;
         din_sync <= 2'b00;
         conf_sync <= 2'b00;
         conf_prev <= 1'b0;
      end else if (clk_en) begin
         sclk_sync <= {sclk_sync[1:0], serial_clk_in};
         din_sync <= {din_sync[0], serial_data_in};
         conf_sync <= {conf_sync[0], conflict_in};
         conf_prev <= conf_sync[1];
      end
   end

   // Master derives edges from a divider, slave from the sampled link clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_count <= 4'h0;
         serial_clk_out <= 1'b0;
         serial_clk_oe <= 1'b0;
      end else if (clk_en) begin
         serial_clk_oe <= master;
         div_count <= (state == SHIFT && master) ? div_count + 4'h1 : 4'h0;
         if (state != SHIFT)
            serial_clk_out <= 1'b0;
         else if (master && div_count == DIV_LAST)
            serial_clk_out <= !serial_clk_out;
      end
   end

   assign sclk_rise = master ? (div_count == DIV_LAST && !serial_clk_out)
                             : (sclk_sync[1] && !sclk_sync[2]);
   assign sclk_fall = master ? (div_count == DIV_LAST && serial_clk_out)
                             : (!sclk_sync[1] && sclk_sync[2]);
   assign byte_end = state == SHIFT && sclk_rise && bit_count == 3'd7;
   assign load_tx = !serial_status_reg[TX_EMPTY_BIT] && tx_allow &&
                    !(master && serial_status_reg[OVERRUN_BIT]);
   assign rx_word = {din_sync[1], shift_reg[7:1]};

   // Bit reversal for MSB-first framing
   for (genvar b = 0; b < 8; b++) begin : g_rev
      assign tx_rev[b] = tx_holding_reg[7 - b];
      assign rx_rev[b] = rx_word[7 - b];
   end

   // Byte engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= IDLE;
         shift_reg <= 8'h00;
         bit_count <= 3'd0;
         rx_holding_reg <= HOLD_RESET;
         serial_data_out <= 1'b0;
      end else if (clk_en) begin
         unique case (state)
            IDLE: begin
               bit_count <= 3'd0;
               if (load_tx) begin
                  shift_reg <= msb_first ? tx_rev : tx_holding_reg;
                  // First bit must stand before a master's first rising edge
                  serial_data_out <= msb_first ? tx_holding_reg[7] : tx_holding_reg[0];
                  state <= SHIFT;
               end else if (rx_allow && !serial_status_reg[OVERRUN_BIT] && !tx_allow) begin
                  state <= SHIFT;
               end
            end
            SHIFT: begin
               if (sclk_fall)
                  serial_data_out <= shift_reg[0];
               if (sclk_rise) begin
                  shift_reg <= {din_sync[1], shift_reg[7:1]};
                  bit_count <= bit_count + 3'd1;
               end
               if (byte_end) begin
                  // keep old byte on overrun
                  // Overrun also drops the received byte of a duplex slave frame started by transmit; the frame still runs
                  if (rx_allow && !serial_status_reg[RX_FULL_BIT] &&
                      !serial_status_reg[OVERRUN_BIT])
                     rx_holding_reg <= msb_first ? rx_rev : rx_word;
                  state <= (rx_allow && serial_enable_reg[RX_ONE_SHOT_BIT]) ? STOPPED : IDLE;
               end
               if (!tx_allow && !rx_allow)
                  state <= IDLE;
            end
            STOPPED: begin
               if (!rx_allow)
                  state <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end

   // Status events
   always_comb begin
      events = 8'h00;
      events[OVERRUN_BIT] = byte_end && rx_allow && serial_status_reg[RX_FULL_BIT];
      events[RX_FULL_BIT] = byte_end && rx_allow && !serial_status_reg[RX_FULL_BIT] &&
                            !serial_status_reg[OVERRUN_BIT];
      events[TX_DONE_BIT] = byte_end && tx_allow && serial_status_reg[TX_EMPTY_BIT];
      events[TX_EMPTY_BIT] = !tx_allow || (state == IDLE && load_tx);
      events[CONFLICT_BIT] = master && conf_sync[1] && !conf_prev;
   end

   // clear by 0 after read of 1
   always_comb begin
      status_clear = 8'h00;
      if (status_write)
         status_clear = read_seen & ~w_data[7:0] & STATUS_MASK;
      if (tx_write) begin
         status_clear[TX_DONE_BIT] = 1'b1;
         status_clear[TX_EMPTY_BIT] = 1'b1;
      end
      if (do_read && s_axi_araddr == RX_HOLD_OFFSET)
         status_clear[RX_FULL_BIT] = 1'b1;
      // Set wins over a clear in the same cycle
      next_status = ((serial_status_reg & ~status_clear) | events) & STATUS_MASK;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_status_reg <= STATUS_RESET;
         read_seen <= 8'h00;
      end else if (clk_en) begin
         serial_status_reg <= next_status;
         if (do_read && s_axi_araddr == STATUS_OFFSET)
            read_seen <= serial_status_reg & STATUS_MASK;
         else
            read_seen <= read_seen & next_status;
      end
   end

   // Sticky copies for the summary interrupt, write one to clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= 8'h00;
      end else if (clk_en) begin
         irq_stat <= (irq_stat & ~((do_write && aw_addr == IRQ_STAT_OFFSET && w_strb[0])
                     ? w_data[7:0] : 8'h00)) | (events & STATUS_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_done_irq <= 1'b0;
         tx_empty_irq <= 1'b0;
         rx_full_irq <= 1'b0;
         overrun_irq <= 1'b0;
         conflict_irq <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         tx_done_irq <= next_status[TX_DONE_BIT] && serial_enable_reg[TX_DONE_IRQ_EN_BIT];
         tx_empty_irq <= next_status[TX_EMPTY_BIT] && serial_enable_reg[TX_EMPTY_IRQ_EN_BIT];
         rx_full_irq <= next_status[RX_FULL_BIT] && serial_enable_reg[RX_IRQ_EN_BIT];
         overrun_irq <= next_status[OVERRUN_BIT] && serial_enable_reg[RX_IRQ_EN_BIT];
         conflict_irq <= next_status[CONFLICT_BIT] && serial_enable_reg[CONFLICT_IRQ_EN_BIT];
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule : sync_serial_enable_status

// >>> serial_checker_asserts.sv
// Port-level checks of the synchronous serial unit
`timescale 1ns/1ps
module serial_checker
   import sync_serial_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic tx_done_irq,
   input wire logic tx_empty_irq,
   input wire logic rx_full_irq,
   input wire logic overrun_irq,
   input wire logic conflict_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic wr_any;
   logic wr_en;
   logic wr_tx;
   logic rd_any;
   // Both write channels are offered together, so they are taken on one edge
   assign wr_any = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign wr_en = wr_any && s_axi_awaddr == ENABLE_OFFSET && s_axi_wstrb[0];
   assign wr_tx = wr_any && s_axi_awaddr == TX_HOLD_OFFSET;
   assign rd_any = s_axi_arvalid && s_axi_arready;
   property p_done_gate; wr_en && !s_axi_wdata[3] |-> ##4 !tx_done_irq; endproperty
   a_done_gate: assert property (p_done_gate) else $error("done request while disabled");
   property p_empty_gate; wr_en && !s_axi_wdata[2] |=> ##3 !tx_empty_irq; endproperty
   a_empty_gate: assert property (p_empty_gate) else $error("empty request while disabled");
   property p_rx_gate; wr_en && !s_axi_wdata[1] |-> ##4 !rx_full_irq && !overrun_irq; endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receive request while disabled");
   property p_conf_gate; wr_en && !s_axi_wdata[0] |-> ##4 !conflict_irq; endproperty
   a_conf_gate: assert property (p_conf_gate) else $error("conflict request while disabled");
   property p_rsv_en; rd_any && s_axi_araddr == ENABLE_OFFSET |=> !s_axi_rdata[4]; endproperty
   a_rsv_en: assert property (p_rsv_en) else $error("reserved enable bit set");
   property p_rsv_st;
      rd_any && s_axi_araddr == STATUS_OFFSET |=>
         s_axi_rvalid && !s_axi_rdata[7] && s_axi_rdata[5:4] == 2'b00;
   endproperty
   a_rsv_st: assert property (p_rsv_st) else $error("reserved status bit set");
   property p_hold_clear; wr_tx |-> ##[1:4] !tx_done_irq; endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("done kept after hold write");
   property p_rx_drop;
      rd_any && s_axi_araddr == RX_HOLD_OFFSET |-> ##[1:4] !rx_full_irq;
   endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("receive request kept after read");
   property p_ovr_cause; $rose(overrun_irq) |-> rx_full_irq; endproperty
   a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without full buffer");
   property p_ovr_stop; overrun_irq |-> !$rose(rx_full_irq); endproperty
   a_ovr_stop: assert property (p_ovr_stop) else $error("reception during overrun");
endmodule : serial_checker
bind sync_serial_enable_status serial_checker chk_i (.*);

// >>> remote_master.sv
// Remote master on the serial link: one byte each way per frame
`timescale 1ns/1ps
module remote_master (
   input wire logic go,
   input wire logic [7:0] tx_byte,
   input wire logic sdi,
   output logic sck,
   output logic sdo,
   output logic busy,
   output logic [7:0] rx_byte
);
   // Clock idles high and stands still between frames
   initial begin
      sck = 1'b1;
      sdo = 1'b0;
      busy = 1'b0;
      rx_byte = 8'h00;
   end
   always @(posedge go) begin
      busy = 1'b1;
      for (int i = 0; i < 8; i++) begin
         #400 sck = 1'b0;
         sdo = tx_byte[i];
         #400 sck = 1'b1;
         rx_byte[i] = sdi;
      end
      // Released line flips so a stale bit is never read as data
      #400 sdo = ~sdo;
      busy = 1'b0;
   end
endmodule : remote_master

// >>> tb_top.sv
// Self-checking bench of the synchronous serial unit in slave and master mode
`timescale 1ns/1ps
module tb_top;
   import sync_serial_pkg::*;
   logic aclk, aresetn, clk_en, conflict_in, serial_clk_in, serial_data_in;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, link_tx, link_rx;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic serial_clk_out, serial_clk_oe, serial_data_out, go, link_busy;
   logic tx_done_irq, tx_empty_irq, rx_full_irq, overrun_irq, conflict_irq, irq;
   int fail_count = 0;
   int n_compared = 0;
   sync_serial_enable_status DUT (.*);
   remote_master peer (.go(go), .tx_byte(link_tx), .sdi(serial_data_out),
      .sck(serial_clk_in), .sdo(serial_data_in), .busy(link_busy), .rx_byte(link_rx));
   initial aclk = 1'b0;
   always #50 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] ev, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h000000, ev});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd
   // One link frame; sync flops need a few cycles to settle after it
   task automatic link(input logic [7:0] b);
      link_tx <= b;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      while (link_busy) @(posedge aclk);
      repeat (6) @(posedge aclk);
   endtask : link
   task automatic settle;
      repeat (2) @(negedge aclk);
   endtask : settle
   task automatic t_regs;
      rd(ENABLE_OFFSET, 8'h00);
      rd(STATUS_OFFSET, 8'h04);
      wr(ENABLE_OFFSET, 8'hff);
      rd(ENABLE_OFFSET, 8'hef);
      settle;
      chk(tx_empty_irq, 1'b1);
      wr(ENABLE_OFFSET, 8'h00);
      settle;
      chk(tx_empty_irq, 1'b0);
      rd(8'h1c, 8'h00, RESP_SLVERR);
      wr(RX_HOLD_OFFSET, 8'h5a, RESP_SLVERR);
      rd(RX_HOLD_OFFSET, 8'h00);
      wr(STATUS_OFFSET, 8'hff);
      rd(STATUS_OFFSET, 8'h04);
      $display("test regs done");
   endtask : t_regs
   task automatic t_rx;
      link(8'h99);
      rd(STATUS_OFFSET, 8'h04);
      wr(IRQ_STAT_OFFSET, 8'hff);
      wr(IRQ_MASK_OFFSET, 8'h00);
      wr(ENABLE_OFFSET, 8'h42);
      link(8'ha5);
      settle;
      chk(rx_full_irq, 1'b1);
      chk(irq, 1'b0);
      wr(IRQ_MASK_OFFSET, 8'h02);
      settle;
      chk(irq, 1'b1);
      wr(IRQ_STAT_OFFSET, 8'h02);
      settle;
      chk(irq, 1'b0);
      rd(STATUS_OFFSET, 8'h06);
      rd(RX_HOLD_OFFSET, 8'ha5);
      settle;
      chk(rx_full_irq, 1'b0);
      $display("test receive done");
   endtask : t_rx
   task automatic t_overrun;
      link(8'h3c);
      link(8'hc3);
      rd(STATUS_OFFSET, 8'h46);
      settle;
      chk(overrun_irq, 1'b1);
      wr(STATUS_OFFSET, 8'hff);
      rd(RX_HOLD_OFFSET, 8'h3c);
      link(8'h77);
      rd(STATUS_OFFSET, 8'h44);
      wr(STATUS_OFFSET, 8'h00);
      rd(STATUS_OFFSET, 8'h04);
      link(8'h81);
      rd(RX_HOLD_OFFSET, 8'h81);
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_one_shot;
      wr(ENABLE_OFFSET, 8'h62);
      link(8'h11);
      rd(RX_HOLD_OFFSET, 8'h11);
      link(8'h22);
      rd(STATUS_OFFSET, 8'h04);
      wr(ENABLE_OFFSET, 8'h00);
      $display("test one shot done");
   endtask : t_one_shot
   task automatic t_tx;
      wr(ENABLE_OFFSET, 8'h8c);
      wr(TX_HOLD_OFFSET, 8'ha5);
      rd(STATUS_OFFSET, 8'h04);
      link(8'h00);
      chk(link_rx, 8'ha5);
      rd(STATUS_OFFSET, 8'h0c);
      settle;
      chk(tx_done_irq, 1'b1);
      wr(TX_HOLD_OFFSET, 8'h3c);
      rd(STATUS_OFFSET, 8'h04);
      $display("test transmit done");
   endtask : t_tx
   task automatic t_msb;
      wr(CTRL_OFFSET, 8'h02);
      wr(ENABLE_OFFSET, 8'h40);
      link(8'h01);
      rd(RX_HOLD_OFFSET, 8'h80);
      $display("test msb first done");
   endtask : t_msb
   task automatic t_master;
      logic [7:0] got;
      logic last_clk;
      int rises;
      got = 8'h00;
      last_clk = 1'b0;
      rises = 0;
      wr(ENABLE_OFFSET, 8'h01);
      wr(CTRL_OFFSET, 8'h01);
      conflict_in <= 1'b1;
      repeat (2) settle;
      chk(conflict_irq, 1'b1);
      chk(serial_clk_oe, 1'b1);
      rd(STATUS_OFFSET, 8'h05);
      wr(STATUS_OFFSET, 8'hfe);
      settle;
      chk(conflict_irq, 1'b0);
      wr(ENABLE_OFFSET, 8'h80);
      wr(TX_HOLD_OFFSET, 8'h5a);
      // Master clocks itself; collect the line at each rising link edge
      repeat (400) begin
         @(negedge aclk);
         if (serial_clk_out && !last_clk) begin
            got = {serial_data_out, got[7:1]};
            rises++;
         end
         last_clk = serial_clk_out;
      end
      chk(got, 8'h5a);
      chk(rises, 8);
      rd(STATUS_OFFSET, 8'h0c);
      $display("test master done");
   endtask : t_master
   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #500000;
      fail_count++;
      $display("ERROR %0t: watchdog expired", $time);
      give_verdict;
   end
   initial begin
      aresetn = 1'b0;
      clk_en = 1'b1;
      conflict_in = 1'b0;
      go = 1'b0;
      link_tx = 8'h00;
      s_axi_wstrb = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_rx;
      t_overrun;
      t_one_shot;
      t_tx;
      t_msb;
      t_master;
      give_verdict;
   end
endmodule : tb_top
